// ==== hdl/gear_scaling_overrun_monitor.sv ====
// Behaviour
// R1 - Select input picks numerator one or two
// R2 - Internal pulses: count times numerator times 2^exp/denominator
// R3 - 2,500-line encoder counts 10,000 per revolution
// R4 - Gear settings accepted only from 1 to 10,000
// R5 - Quadrature input multiplied by 2 or 4
// R6 - Beyond allowed range: stop, raise alarm 34
// R7 - Check only in control modes 0, 3, 4
// R8 - Check needs servo on, nonzero setting, bounded range
// R9 - Servo off disables check until range clear
// R10 - Servo off with zero setting clears range
// R11 - Range starts at zero after power-up
// R12 - Deviation clear or servo-lock prohibit clears range
// R13 - Autotuning start and end clear range
// R14 - No commands: setting travel around reference
// R15 - Commands widen range plus travel each side
// R16 - Opposite commands enlarge, never shrink, range
// R17 - Compare every cycle, alarm latched until reset
// R18 - Host holds numerator select steady during motion
`include "gear_overrun_defs.svh"
`default_nettype none
module gear_scaling_overrun_monitor
  import gear_overrun_pkg::*;
#(
  parameter logic [31:0] ENCODER_LINES = `ENCODER_LINES
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_pin_a,
  input wire logic cmd_pin_b,
  input wire logic command_pulse_format,
  input wire logic command_pulse_input_select,
  input wire logic gear_numerator_select,
  input wire gear_t gear_numerator_one,
  input wire gear_t gear_numerator_two,
  input wire logic [4:0] gear_exponent,
  input wire gear_t gear_denominator,
  input wire logic [3:0] control_mode_select,
  input wire logic servo_on,
  input wire logic [15:0] overrun_range_setting,
  input wire logic deviation_clear,
  input wire logic drive_prohibit,
  input wire logic [1:0] drive_prohibit_stop_select,
  input wire logic autotune_busy,
  input wire logic alarm_reset,
  input wire pos_t feedback_position,
  output var pos_t command_position,
  output logic overrun_alarm,
  output logic [7:0] alarm_code,
  output logic motor_stop,
  output logic overrun_check_active,
  output logic gear_setting_error
);
  localparam logic [31:0] COUNTS_PER_REV =
    ENCODER_LINES * `QUAD_FACTOR; // R3

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic a_meta_r, a_sync_r, a_prev_r;
  logic b_meta_r, b_sync_r, b_prev_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      a_meta_r <= 1'b0;
      a_sync_r <= 1'b0;
      a_prev_r <= 1'b0;
      b_meta_r <= 1'b0;
      b_sync_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      a_meta_r <= cmd_pin_a;
      a_sync_r <= a_meta_r;
      a_prev_r <= a_sync_r;
      b_meta_r <= cmd_pin_b;
      b_sync_r <= b_meta_r;
      b_prev_r <= b_sync_r;
    end
  end

  logic a_edge, b_edge;
  logic step_valid, step_up;
  assign a_edge = a_sync_r ^ a_prev_r;
  assign b_edge = b_sync_r ^ b_prev_r;

  // ------------------------------------------------------------
  // Command pulse decoder
  // ------------------------------------------------------------
  always_comb begin
    step_valid = 1'b0;
    step_up = 1'b0;
    if (command_pulse_format == `FMT_QUADRATURE) begin
      if (a_edge && !b_edge) begin
        step_valid = 1'b1; // R5
        step_up = a_sync_r ^ b_sync_r;
      end else if (b_edge && !a_edge &&
                   command_pulse_input_select == `MULT_X4) begin
        step_valid = 1'b1; // R5
        step_up = ~(a_sync_r ^ b_sync_r);
      end
    end else begin
      step_valid = a_sync_r && !a_prev_r;
      step_up = ~b_sync_r;
    end
  end

  // ------------------------------------------------------------
  // Electronic gear
  // ------------------------------------------------------------
  gear_t num_sel;
  logic gear_ok;
  assign num_sel = (gear_numerator_select == `GEAR_SEL_ONE) ?
                   gear_numerator_one : gear_numerator_two; // R1 R18
  assign gear_ok =
    gear_numerator_one >= `GEAR_SET_MIN &&
    gear_numerator_one <= `GEAR_SET_MAX &&
    gear_numerator_two >= `GEAR_SET_MIN &&
    gear_numerator_two <= `GEAR_SET_MAX &&
    gear_denominator >= `GEAR_SET_MIN &&
    gear_denominator <= `GEAR_SET_MAX; // R4

  gear_scale_if gsi ();
  assign gsi.step_valid = step_valid;
  assign gsi.step_up = step_up;
  assign gsi.scale_enable = gear_ok; // R4
  assign gsi.gear_num = num_sel;
  assign gsi.gear_exp = gear_exponent;
  assign gsi.gear_den = gear_denominator;

  gear_scaler u_scaler (
    .clk_sys (clk_sys),
    .resetn (resetn),
    .gs (gsi.scaler)
  );

  logic gear_err_r;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gear_err_r <= 1'b0;
    end else begin
      gear_err_r <= ~gear_ok; // R4
    end
  end

  // ------------------------------------------------------------
  // Internal command position
  // ------------------------------------------------------------
  pos_t cmd_pos_r, cmd_pos_nxt;
  always_comb begin
    cmd_pos_nxt = cmd_pos_r;
    if (gsi.out_valid) begin
      cmd_pos_nxt = gsi.out_up ? cmd_pos_r + 32'sh1 : cmd_pos_r - 32'sh1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmd_pos_r <= `POS_RESET;
    end else begin
      cmd_pos_r <= cmd_pos_nxt;
    end
  end

  // ------------------------------------------------------------
  // Position command input range
  // ------------------------------------------------------------
  logic tune_prev_r;
  logic range_clear;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tune_prev_r <= 1'b0;
    end else begin
      tune_prev_r <= autotune_busy;
    end
  end

  assign range_clear =
    (!servo_on && overrun_range_setting == 16'h0) || // R10
    deviation_clear ||
    (drive_prohibit &&
     drive_prohibit_stop_select == `PROHIBIT_SERVO_LOCK) || // R12
    (autotune_busy ^ tune_prev_r); // R13

  pos_t ref_r, min_rel_r, max_rel_r, rel_nxt;
  assign rel_nxt = cmd_pos_nxt - ref_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ref_r <= `POS_RESET; // R11
      min_rel_r <= `RANGE_RESET; // R11
      max_rel_r <= `RANGE_RESET;
    end else if (range_clear) begin
      ref_r <= cmd_pos_nxt; // R10 R12 R13
      min_rel_r <= `RANGE_RESET;
      max_rel_r <= `RANGE_RESET;
    end else begin
      if (rel_nxt < min_rel_r) begin
        min_rel_r <= rel_nxt; // R15 R16
      end
      if (rel_nxt > max_rel_r) begin
        max_rel_r <= rel_nxt; // R15 R16
      end
    end
  end

  logic armed_r;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      armed_r <= 1'b1;
    end else if (range_clear) begin
      armed_r <= 1'b1; // R9
    end else if (!servo_on) begin
      armed_r <= 1'b0; // R9
    end
  end

  // ------------------------------------------------------------
  // Allowable window, registered
  // ------------------------------------------------------------
  wide_t travel, hi_w, lo_w;
  wide_t hi_r, lo_r;
  logic bounded_r;
  assign travel = wide_t'({32'h0, overrun_range_setting}) *
                  wide_t'({16'h0, COUNTS_PER_REV});
  assign hi_w = wide_t'(max_rel_r) + travel; // R14 R15
  assign lo_w = wide_t'(min_rel_r) - travel; // R14 R15

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hi_r <= 48'sh0;
      lo_r <= 48'sh0;
      bounded_r <= 1'b0;
    end else begin
      hi_r <= hi_w;
      lo_r <= lo_w;
      bounded_r <= (hi_w <= `RANGE_LIMIT) && (-lo_w <= `RANGE_LIMIT); // R8
    end
  end

  logic mode_ok;
  logic check_r;
  assign mode_ok = control_mode_select == `MODE_POSITION ||
                   control_mode_select == `MODE_POS_SPEED ||
                   control_mode_select == `MODE_POS_TORQUE; // R7

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      check_r <= 1'b0;
    end else begin
      check_r <= mode_ok && servo_on && armed_r && bounded_r &&
                 overrun_range_setting != 16'h0 && !range_clear; // R7 R8 R9
    end
  end

  // ------------------------------------------------------------
  // Overrun compare and alarm
  // ------------------------------------------------------------
  wide_t fb_rel;
  logic outside;
  assign fb_rel = wide_t'(feedback_position) - wide_t'(ref_r);
  assign outside = fb_rel > hi_r || fb_rel < lo_r; // R17

  logic alarm_r, stop_r;
  logic [7:0] code_r;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      alarm_r <= 1'b0;
    end else if (check_r && outside) begin
      alarm_r <= 1'b1; // R6 R17
    end else if (alarm_reset) begin
      alarm_r <= 1'b0; // R17
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      code_r <= 8'h00;
      stop_r <= 1'b0;
    end else begin
      code_r <= (alarm_r || (check_r && outside)) ? `OVR_ALARM_CODE : 8'h00;
      stop_r <= alarm_r || (check_r && outside); // R6
    end
  end

  assign command_position = cmd_pos_r;
  assign overrun_alarm = alarm_r;
  assign alarm_code = code_r;
  assign motor_stop = stop_r;
  assign overrun_check_active = check_r;
  assign gear_setting_error = gear_err_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_violation;
    check_r && outside;
  endsequence

  sequence s_alarm_raised;
    alarm_r && stop_r && code_r == 8'h22;
  endsequence

  a_alarm_raise: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_violation |=> s_alarm_raised) // R6
    else $error("overrun did not raise alarm 34 with stop");

  a_alarm_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (alarm_r && !alarm_reset) |=> alarm_r) // R17
    else $error("overrun alarm dropped without reset");

  a_mode_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(control_mode_select inside {4'h0, 4'h3, 4'h4}) |=> !check_r) // R7
    else $error("overrun check active in non-position mode");

  a_zero_setting: assert property (@(posedge clk_sys) disable iff (!resetn)
    (overrun_range_setting == 16'h0 || !servo_on) |=> !check_r) // R8
    else $error("overrun check active with servo off or zero setting");

  a_servo_disarm: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!servo_on && !range_clear) |=> !armed_r) // R9
    else $error("servo off did not disarm overrun check");

  a_range_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    range_clear |=> (min_rel_r == 32'sh0 && max_rel_r == 32'sh0 &&
                     ref_r == $past(cmd_pos_nxt))) // R10 R12 R13
    else $error("range not zeroed on clear");

  a_range_grow: assert property (@(posedge clk_sys) disable iff (!resetn)
    !range_clear |=> (max_rel_r >= $past(max_rel_r) &&
                      min_rel_r <= $past(min_rel_r))) // R16
    else $error("command range shrank without clear");

  a_gear_reject: assert property (@(posedge clk_sys) disable iff (!resetn)
    (gear_denominator == 14'h0 || gear_denominator > 14'h2710)
      |=> gear_err_r) // R4
    else $error("out-of-range gear setting accepted");

  a_window_travel: assert property (@(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> (hi_r - lo_r == wide_t'($past(max_rel_r)) -
              wide_t'($past(min_rel_r)) + 2 * $past(travel))) // R14 R15
    else $error("window does not add travel on both sides");

  a_x2_ignores_b: assert property (@(posedge clk_sys) disable iff (!resetn)
    (command_pulse_format == 1'b0 && command_pulse_input_select == 1'b0 &&
     !a_edge) |-> !step_valid) // R5
    else $error("x2 quadrature counted a B edge");
endmodule
`default_nettype wire

// ==== hdl/gear_overrun_defs.svh ====
`ifndef GEAR_OVERRUN_DEFS_SVH
`define GEAR_OVERRUN_DEFS_SVH

// ------------------------------------------------------------
// Gear settings
// ------------------------------------------------------------
`define GEAR_SET_MIN 14'h0001
`define GEAR_SET_MAX 14'h2710
`define GEAR_SEL_ONE 1'h0

// ------------------------------------------------------------
// Command pulse decoding
// ------------------------------------------------------------
`define FMT_QUADRATURE 1'h0
`define MULT_X4 1'h1
`define ENCODER_LINES 32'h000009C4
`define QUAD_FACTOR 32'h00000004

// ------------------------------------------------------------
// Overrun monitor
// ------------------------------------------------------------
`define MODE_POSITION 4'h0
`define MODE_POS_SPEED 4'h3
`define MODE_POS_TORQUE 4'h4
`define PROHIBIT_SERVO_LOCK 2'h2
`define OVR_ALARM_CODE 8'h22
`define RANGE_LIMIT 48'sh00007FFFFFFF
`define RANGE_RESET 32'h00000000
`define POS_RESET 32'h00000000

`endif

// ==== hdl/gear_overrun_pkg.sv ====
`default_nettype none
package gear_overrun_pkg;
  typedef logic signed [31:0] pos_t;
  typedef logic signed [47:0] wide_t;
  typedef logic [13:0] gear_t;
endpackage
`default_nettype wire

// ==== hdl/gear_scale_if.sv ====
`default_nettype none
interface gear_scale_if;
  import gear_overrun_pkg::*;
  logic step_valid;
  logic step_up;
  logic scale_enable;
  gear_t gear_num;
  logic [4:0] gear_exp;
  gear_t gear_den;
  logic out_valid;
  logic out_up;
  modport scaler (
    input step_valid, step_up, scale_enable, gear_num, gear_exp, gear_den,
    output out_valid, out_up
  );
  modport user (
    output step_valid, step_up, scale_enable, gear_num, gear_exp, gear_den,
    input out_valid, out_up
  );
endinterface
`default_nettype wire

// ==== hdl/gear_scaler.sv ====
`include "gear_overrun_defs.svh"
`default_nettype none
module gear_scaler
  import gear_overrun_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  gear_scale_if.scaler gs
);
  wide_t rem_r;
  wide_t rem_nxt;
  wide_t gain;
  wide_t den_w;
  logic out_valid_r;
  logic out_up_r;
  logic emit_up;
  logic emit_dn;

  // ------------------------------------------------------------
  // Numerator times two to the exponent, spread over the divisor
  // ------------------------------------------------------------
  always_comb begin
    gain = wide_t'({34'h0, gs.gear_num}) <<< gs.gear_exp; // R2
    den_w = wide_t'({34'h0, gs.gear_den});
    // Bad settings freeze the remainder, no runaway on zero divisor
    emit_up = gs.scale_enable && (rem_r >= den_w);
    emit_dn = gs.scale_enable && (rem_r < 48'sh0);
    rem_nxt = rem_r;
    if (gs.step_valid && gs.scale_enable) begin
      rem_nxt = gs.step_up ? rem_r + gain : rem_r - gain; // R2
    end
    if (emit_up) begin
      rem_nxt = rem_nxt - den_w; // R2
    end else if (emit_dn) begin
      rem_nxt = rem_nxt + den_w;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rem_r <= 48'sh0;
    end else begin
      rem_r <= rem_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_valid_r <= 1'b0;
      out_up_r <= 1'b0;
    end else begin
      out_valid_r <= emit_up || emit_dn;
      out_up_r <= emit_up;
    end
  end

  assign gs.out_valid = out_valid_r;
  assign gs.out_up = out_up_r;

  a_scale_up_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    emit_up |=> (out_valid_r && out_up_r)) // R2
    else $error("scaler missed an upward internal pulse");
endmodule
`default_nettype wire

// ==== dv/host_cmd_model.sv ====
`default_nettype none
module host_cmd_model (
  input wire logic clk_sys,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gray phase: one pin changes per step, A leads B going up
  logic [1:0] phase = 2'h0;
  assign pin_a = phase[0] ^ phase[1];
  assign pin_b = phase[1];
  task automatic move(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      phase = up ? phase + 2'h1 : phase - 2'h1;
      repeat (3) @(negedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/gear_scaling_overrun_monitor_test.sv ====
`default_nettype none
module gear_scaling_overrun_monitor_test
  import gear_overrun_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Stimulus and design
  // ------
  localparam logic [31:0] LINES = 32'h0000000A;
  localparam pos_t TRAVEL = pos_t'(4 * LINES);
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic pin_a, pin_b;
  logic fmt = 1'h0, in_sel = 1'h1, gsel = 1'h0, servo = 1'h1;
  gear_t num1 = 14'h0001, num2 = 14'h0001, den = 14'h0001;
  logic [4:0] gexp = 5'h00;
  logic [3:0] mode = 4'h0;
  logic [15:0] ovr = 16'h0001;
  logic dev_clr = 1'h0, prohibit = 1'h0, tune = 1'h0, a_rst = 1'h0;
  logic [1:0] stop_sel = 2'h0;
  pos_t fb = 32'h00000000;
  pos_t pos = 32'h00000000;
  pos_t base;
  pos_t cmd_pos;
  logic alarm, stop, active, gerr;
  logic [7:0] code;
  int errors = 0;
  int checked = 0;
  always #2 clk_sys = ~clk_sys;
  host_cmd_model host (.clk_sys(clk_sys), .pin_a(pin_a), .pin_b(pin_b));
  gear_scaling_overrun_monitor #(.ENCODER_LINES(LINES)) uut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cmd_pin_a(pin_a),
    .cmd_pin_b(pin_b),
    .command_pulse_format(fmt),
    .command_pulse_input_select(in_sel),
    .gear_numerator_select(gsel),
    .gear_numerator_one(num1),
    .gear_numerator_two(num2),
    .gear_exponent(gexp),
    .gear_denominator(den),
    .control_mode_select(mode),
    .servo_on(servo),
    .overrun_range_setting(ovr),
    .deviation_clear(dev_clr),
    .drive_prohibit(prohibit),
    .drive_prohibit_stop_select(stop_sel),
    .autotune_busy(tune),
    .alarm_reset(a_rst),
    .feedback_position(fb),
    .command_position(cmd_pos),
    .overrun_alarm(alarm),
    .alarm_code(code),
    .motor_stop(stop),
    .overrun_check_active(active),
    .gear_setting_error(gerr)
  );
  // ------
  // Helpers
  // ------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want,
                       input string what);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: %s %0h not %0h", $time, what, seen, want);
    end
  endtask
  task automatic move(input int n, input logic up, input pos_t d);
    host.move(n, up);
    pos = pos + d;
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < 200 && cmd_pos !== pos; i++) @(negedge clk_sys);
    check(cmd_pos, pos, "position");
    if (cmd_pos !== pos) close_out();
  endtask
  task automatic probe(input pos_t v, input logic hit);
    fb = v;
    repeat (3) @(negedge clk_sys);
    check(alarm, hit, "alarm");
    check(code, hit ? 8'h22 : 8'h00, "code");
    check(stop, hit, "stop");
    fb = pos;
    repeat (3) @(negedge clk_sys);
    check(alarm, hit, "latched");
    a_rst = 1'h1;
    @(negedge clk_sys);
    a_rst = 1'h0;
    repeat (2) @(negedge clk_sys);
    check(alarm, 1'h0, "cleared");
    check(stop, 1'h0, "stop cleared");
  endtask
  task automatic gate(input logic want);
    repeat (3) @(negedge clk_sys);
    check(active, want, "check gate");
  endtask
  task automatic cycle_servo();
    servo = 1'h0;
    gate(1'h0);
    servo = 1'h1;
    gate(1'h0);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic test_window();
    gate(1'h1);
    probe(TRAVEL, 1'h0);
    probe(TRAVEL + 1, 1'h1);
    probe(-TRAVEL, 1'h0);
    probe(-TRAVEL - 1, 1'h1);
    $display("window done");
  endtask
  task automatic test_gear();
    num1 = 14'h0003;
    num2 = 14'h0005;
    gexp = 5'h01;
    den = 14'h0002;
    move(4, 1'h1, 12);
    gsel = 1'h1;
    move(4, 1'h1, 20);
    in_sel = 1'h0;
    move(4, 1'h0, -10);
    in_sel = 1'h1;
    gsel = 1'h0;
    num1 = 14'h0001;
    gexp = 5'h00;
    den = 14'h0003;
    move(6, 1'h1, 2);
    $display("gear done");
  endtask
  task automatic test_limits();
    den = 14'h0000;
    gate(1'h1);
    check(gerr, 1'h1, "gear error");
    move(4, 1'h1, 0);
    den = 14'h2711;
    gate(1'h1);
    check(gerr, 1'h1, "gear error");
    den = 14'h2710;
    gate(1'h1);
    check(gerr, 1'h0, "gear error");
    num2 = 14'h2711;
    gate(1'h1);
    check(gerr, 1'h1, "gear error");
    num2 = 14'h0001;
    den = 14'h0001;
    move(4, 1'h1, 4);
    fmt = 1'h1;
    move(4, 1'h1, 1);
    move(4, 1'h0, -1);
    fmt = 1'h0;
    $display("limits done");
  endtask
  task automatic test_span();
    servo = 1'h0;
    ovr = 16'h0000;
    gate(1'h0);
    servo = 1'h1;
    ovr = 16'h0001;
    gate(1'h1);
    base = pos;
    probe(base + TRAVEL + 1, 1'h1);
    move(4, 1'h1, 4);
    probe(pos + TRAVEL, 1'h0);
    probe(pos + TRAVEL + 1, 1'h1);
    move(8, 1'h0, -8);
    probe(base + 4 + TRAVEL, 1'h0);
    probe(pos - TRAVEL, 1'h0);
    probe(pos - TRAVEL - 1, 1'h1);
    $display("span done");
  endtask
  task automatic test_clear();
    dev_clr = 1'h1;
    @(negedge clk_sys);
    dev_clr = 1'h0;
    probe(pos + TRAVEL + 1, 1'h1);
    cycle_servo();
    dev_clr = 1'h1;
    gate(1'h0);
    dev_clr = 1'h0;
    gate(1'h1);
    cycle_servo();
    prohibit = 1'h1;
    stop_sel = 2'h1;
    gate(1'h0);
    stop_sel = 2'h2;
    gate(1'h0);
    prohibit = 1'h0;
    gate(1'h1);
    cycle_servo();
    tune = 1'h1;
    gate(1'h1);
    cycle_servo();
    tune = 1'h0;
    gate(1'h1);
    for (int m = 0; m < 6; m++) begin
      mode = 4'(m);
      gate(m == 0 || m == 3 || m == 4);
    end
    mode = 4'h0;
    ovr = 16'h0000;
    gate(1'h0);
    ovr = 16'h0001;
    gate(1'h1);
    $display("clear done");
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    resetn = 1'h1;
    check(cmd_pos, 32'h00000000, "reset position");
    check(alarm, 1'h0, "reset alarm");
    check(stop, 1'h0, "reset stop");
    test_window();
    test_gear();
    test_limits();
    test_span();
    test_clear();
    close_out();
  end
endmodule
`default_nettype wire
